// File: src/spc_core.sv
// Digital control core: soft start, jittered oscillator, pulse latch, blanking and burst/restart timers.
//
// Summary of operation
// - Soft start begins when supply rises above the on-threshold.
// - Soft start reference rises in 32 counter-driven steps.
// - One step every 300us, lowering sink so permitted duty grows.
// - Soft start ends 10ms after switch-on; the sink is then disabled.
// - Allowed duty grows from zero to normal maximum during soft start.
// - Every auto-restart attempt reruns the full soft start.
// - Switch at 100kHz, jittered by 4 percent over a 4ms period.
// - On-time never exceeds 0.75 of the switching period.
// - Jitter only in normal operation; fixed frequency before.
// - Oscillator sets the latch; duty, soft start or limit comparators clear it.
// - Gate goes off at once whenever the latch is cleared.
// - Gate held low while supply is below the off-threshold.
// - Peak current over limit clears the latch at once.
// - Limit, burst limit and duty comparators ignored 220ns after turn-on.
// - In burst mode the reduced current limit comparator is enabled.
// - Short-winding detection must persist 190ns before latching off.
// - 20ms blanking must elapse before burst or restart entry.
// - After 20ms the blanking pin clamp is released to charge.
// - Pin at 4.0V plus 25us spike blanking activates auto restart.
// - Overload blanking timer stays disabled until start up completes.
// - Burst uses basic blanking; restart uses basic plus extendable blanking.
// - Feedback below 1.23V for 20ms enters burst mode.
// - Feedback above 4.2V starts the overload blanking count.
`default_nettype none
module spc_core
  import spc_pkg::*;
#(
  parameter int SS_CYC = SS_CYCLES,
  parameter int STEP_CYC = STEP_CYCLES,
  parameter int BLANK_CYC = BLANK_CYCLES,
  parameter int JIT_CYC = JITTER_CYCLES_TOTAL
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic supply_on_i,
  input wire logic supply_ok_i,
  input wire logic duty_cmp_i,
  input wire logic peak_limit_cmp_i,
  input wire logic burst_limit_cmp_i,
  input wire logic short_winding_cmp_i,
  input wire logic fb_low_cmp_i,
  input wire logic fb_high_cmp_i,
  input wire logic blanking_level_cmp_i,
  input wire logic restart_done_i,
  output logic gate_o,
  output logic [4:0] soft_start_reference_o,
  output logic soft_start_sink_o,
  output logic blanking_clamp_switch_o,
  output logic burst_mode_o,
  output logic auto_restart_o,
  output logic latched_off_o
);
  localparam int PW = $clog2(PERIOD_CYCLES + JITTER_CYCLES + 1);
  localparam int SW = $clog2(SS_CYC + 1);
  localparam int KW = $clog2(STEP_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int JW = $clog2(JIT_CYC + 1);
  localparam int RW = $clog2(RESTART_SPIKE_CYCLES + 1);
  localparam int WW = $clog2(SWD_CYCLES + 1);
  localparam int JSTEP = JIT_CYC / (4 * JITTER_CYCLES);

  // Pin inputs pass two flip-flops before any logic reads them.
  localparam int NIN = 10;
  logic [NIN-1:0] raw, s1, s2;
  assign raw = {supply_on_i, supply_ok_i, duty_cmp_i, peak_limit_cmp_i, burst_limit_cmp_i,
                short_winding_cmp_i, fb_low_cmp_i, fb_high_cmp_i, blanking_level_cmp_i,
                restart_done_i};
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic on_s, ok_s, duty_s, peak_s, bl_s, sw_s, fbl_s, fbh_s, blv_s, rdone_s;
  assign {on_s, ok_s, duty_s, peak_s, bl_s, sw_s, fbl_s, fbh_s, blv_s, rdone_s} = s2;

  spc_mode_type mode, next_mode;
  logic [SW-1:0] ss_cnt, next_ss_cnt;
  logic [KW-1:0] step_cnt, next_step_cnt;
  logic [4:0] ref_lvl, next_ref_lvl;
  logic [PW-1:0] ph, next_ph, per, next_per;
  logic [JW-1:0] jcnt, next_jcnt;
  logic [PW-1:0] jofs, next_jofs;
  logic jup, next_jup;
  logic latch, next_latch;
  logic [PW-1:0] on_cnt, next_on_cnt;
  logic [BW-1:0] bcnt, next_bcnt, ocnt, next_ocnt;
  logic [RW-1:0] rcnt, next_rcnt;
  logic [WW-1:0] swcnt, next_swcnt;
  logic burst, next_burst, clamp, next_clamp, restart, next_restart, lat_off, next_lat_off;
  logic [PW-1:0] max_on, ss_on;
  logic blank_done, reset_cond, osc_pulse;

  always_comb begin
    next_mode = mode;
    next_ss_cnt = ss_cnt;
    next_step_cnt = step_cnt;
    next_ref_lvl = ref_lvl;
    reset_cond = !ok_s || lat_off;
    unique case (mode)
      SPC_OFF: begin
        if (on_s && !lat_off) begin
          next_mode = SPC_SOFT;
          next_ss_cnt = '0;
          next_step_cnt = '0;
          next_ref_lvl = '0;
        end
      end
      SPC_SOFT: begin
        next_ss_cnt = SW'(ss_cnt + 1'b1);
        if (step_cnt == KW'(STEP_CYC - 1)) begin
          next_step_cnt = '0;
          if (ref_lvl != 5'(SS_STEPS - 1)) begin
            next_ref_lvl = ref_lvl + 5'h01;
          end
        end else begin
          next_step_cnt = KW'(step_cnt + 1'b1);
        end
        if (ss_cnt == SW'(SS_CYC - 1)) begin
          next_mode = SPC_NORMAL;
        end
      end
      SPC_NORMAL: begin
        if (restart) begin
          next_mode = SPC_HALT;
        end
      end
      SPC_HALT: begin
        // Each restart attempt goes back through the full soft start.
        if (rdone_s) begin
          next_mode = SPC_OFF;
        end
      end
    endcase
    if (reset_cond) begin
      next_mode = SPC_OFF;
      next_ref_lvl = '0;
    end
  end

  // Oscillator with triangular jitter of the period in normal mode only.
  always_comb begin
    next_jcnt = jcnt;
    next_jofs = jofs;
    next_jup = jup;
    if (mode == SPC_NORMAL) begin
      if (jcnt == JW'(JSTEP - 1)) begin
        next_jcnt = '0;
        if (jup) begin
          next_jofs = PW'(jofs + 1'b1);
          if (jofs == PW'(2 * JITTER_CYCLES - 1)) begin
            next_jup = 1'b0;
          end
        end else begin
          next_jofs = PW'(jofs - 1'b1);
          if (jofs == PW'(1)) begin
            next_jup = 1'b1;
          end
        end
      end else begin
        next_jcnt = JW'(jcnt + 1'b1);
      end
    end else begin
      next_jcnt = '0;
      next_jofs = PW'(JITTER_CYCLES);
      next_jup = 1'b1;
    end
    osc_pulse = (ph == PW'(per - 1'b1));
    next_ph = osc_pulse ? '0 : PW'(ph + 1'b1);
    // Period span is 100kHz plus or minus 4 percent.
    next_per = osc_pulse ? PW'(PERIOD_CYCLES - JITTER_CYCLES) + next_jofs : per;
  end

  // Pulse latch with duty limit, blanking and comparator resets.
  always_comb begin
    max_on = PW'((per * MAX_DUTY_LIMIT_NUM) / MAX_DUTY_LIMIT_DEN);
    ss_on = PW'((max_on * ref_lvl) / SS_STEPS);
    next_latch = latch;
    next_on_cnt = latch ? PW'(on_cnt + 1'b1) : '0;
    if (mode == SPC_OFF || mode == SPC_HALT || !ok_s || lat_off || restart) begin
      next_latch = 1'b0;
    end else if (osc_pulse && !(mode == SPC_SOFT && ss_on == '0)) begin
      next_latch = 1'b1;
      next_on_cnt = '0;
    end else if (latch) begin
      if (PW'(on_cnt + 1'b1) >= max_on) begin
        next_latch = 1'b0;
      end else if (mode == SPC_SOFT && PW'(on_cnt + 1'b1) >= ss_on) begin
        next_latch = 1'b0;
      end else if (on_cnt >= PW'(LEB_CYCLES)) begin
        if (peak_s || duty_s || (burst && bl_s)) begin
          next_latch = 1'b0;
        end
      end
    end
  end

  // Burst and overload blanking, restart chain, short-winding filter.
  always_comb begin
    next_bcnt = bcnt;
    next_ocnt = ocnt;
    next_burst = burst;
    next_clamp = clamp;
    next_rcnt = rcnt;
    next_restart = restart;
    next_swcnt = swcnt;
    next_lat_off = lat_off;
    blank_done = 1'b0;
    if (mode != SPC_NORMAL) begin
      next_bcnt = '0;
      next_ocnt = '0;
      next_clamp = 1'b1;
      next_rcnt = '0;
      next_burst = 1'b0;
    end else begin
      if (fbl_s && !burst) begin
        if (bcnt == BW'(BLANK_CYC - 1)) begin
          next_burst = 1'b1;
          next_bcnt = '0;
        end else begin
          next_bcnt = BW'(bcnt + 1'b1);
        end
      end else begin
        next_bcnt = '0;
      end
      if (fbh_s) begin
        next_burst = 1'b0;
        if (ocnt == BW'(BLANK_CYC - 1)) begin
          blank_done = 1'b1;
        end else begin
          next_ocnt = BW'(ocnt + 1'b1);
        end
        if (blank_done) begin
          next_clamp = 1'b0;
        end
      end else begin
        next_ocnt = '0;
        next_clamp = 1'b1;
      end
      if (!clamp && blv_s) begin
        if (rcnt == RW'(RESTART_SPIKE_CYCLES - 1)) begin
          next_restart = 1'b1;
        end else begin
          next_rcnt = RW'(rcnt + 1'b1);
        end
      end else begin
        next_rcnt = '0;
      end
    end
    if (mode == SPC_HALT && rdone_s) begin
      next_restart = 1'b0;
    end
    // Short spikes on the short-winding detector must not latch the part off.
    if (sw_s && latch) begin
      if (swcnt == WW'(SWD_CYCLES - 1)) begin
        next_lat_off = 1'b1;
      end else begin
        next_swcnt = WW'(swcnt + 1'b1);
      end
    end else begin
      next_swcnt = '0;
    end
    if (!on_s && !ok_s) begin
      next_lat_off = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode <= SPC_OFF;
      ss_cnt <= '0;
      step_cnt <= '0;
      ref_lvl <= '0;
      ph <= '0;
      per <= PW'(PERIOD_CYCLES);
      jcnt <= '0;
      jofs <= PW'(JITTER_CYCLES);
      jup <= 1'b1;
      latch <= 1'b0;
      on_cnt <= '0;
      bcnt <= '0;
      ocnt <= '0;
      rcnt <= '0;
      swcnt <= '0;
      burst <= 1'b0;
      clamp <= 1'b1;
      restart <= 1'b0;
      lat_off <= 1'b0;
    end else begin
      mode <= next_mode;
      ss_cnt <= next_ss_cnt;
      step_cnt <= next_step_cnt;
      ref_lvl <= next_ref_lvl;
      ph <= next_ph;
      per <= next_per;
      jcnt <= next_jcnt;
      jofs <= next_jofs;
      jup <= next_jup;
      latch <= next_latch;
      on_cnt <= next_on_cnt;
      bcnt <= next_bcnt;
      ocnt <= next_ocnt;
      rcnt <= next_rcnt;
      swcnt <= next_swcnt;
      burst <= next_burst;
      clamp <= next_clamp;
      restart <= next_restart;
      lat_off <= next_lat_off;
    end
  end

  // Outputs are registered from the next-state values; the gate changes in the same cycle as the latch.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_o <= 1'b0;
      soft_start_reference_o <= '0;
      soft_start_sink_o <= 1'b0;
      blanking_clamp_switch_o <= 1'b1;
      burst_mode_o <= 1'b0;
      auto_restart_o <= 1'b0;
      latched_off_o <= 1'b0;
    end else begin
      gate_o <= next_latch;
      soft_start_reference_o <= next_ref_lvl;
      soft_start_sink_o <= (next_mode == SPC_SOFT);
      blanking_clamp_switch_o <= next_clamp;
      burst_mode_o <= next_burst;
      auto_restart_o <= next_restart;
      latched_off_o <= next_lat_off;
    end
  end
endmodule
`default_nettype wire

// File: src/spc_pkg.sv
// Package with timing constants and state types for the switching supply control core.
`default_nettype none
package spc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int STEP_TIME_US = 300;
  localparam int STEP_CYCLES = STEP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SS_STEPS = 32;
  localparam int SS_TIME_MS = 10;
  localparam int SS_CYCLES = SS_TIME_MS * (CLK_HZ / 1000);
  localparam int SW_FREQ_HZ = 100_000;
  localparam int PERIOD_CYCLES = CLK_HZ / SW_FREQ_HZ;
  localparam int JITTER_PCT = 4;
  localparam int JITTER_CYCLES = (PERIOD_CYCLES * JITTER_PCT) / 100;
  localparam int JITTER_TIME_MS = 4;
  localparam int JITTER_CYCLES_TOTAL = JITTER_TIME_MS * (CLK_HZ / 1000);
  localparam int MAX_DUTY_LIMIT_NUM = 3;
  localparam int MAX_DUTY_LIMIT_DEN = 4;
  localparam int LEB_TIME_NS = 220;
  localparam int LEB_CYCLES = (LEB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SWD_TIME_NS = 190;
  localparam int SWD_CYCLES = (SWD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BLANK_TIME_MS = 20;
  localparam int BLANK_CYCLES = BLANK_TIME_MS * (CLK_HZ / 1000);
  localparam int RESTART_SPIKE_US = 25;
  localparam int RESTART_SPIKE_CYCLES = RESTART_SPIKE_US * (CLK_HZ / 1_000_000);
  typedef enum logic [1:0] {
    SPC_OFF,
    SPC_SOFT,
    SPC_NORMAL,
    SPC_HALT
  } spc_mode_type;
endpackage
`default_nettype wire

// File: testbench/spc_switch_model.sv
// Model of the power switch and its sense network, seen only as comparator results.
`default_nettype none
module spc_switch_model (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic [7:0] duty_at_i,
  input wire logic [7:0] peak_at_i,
  input wire logic [7:0] burst_at_i,
  input wire logic [1:0] spike_i,
  output logic duty_cmp_o,
  output logic peak_cmp_o,
  output logic burst_cmp_o
);
  logic [7:0] ramp = 8'h00;
  // Current ramps while the switch conducts and is zero while it is off.
  always @(posedge clk_i) ramp <= gate_i ? ramp + 8'h01 : 8'h00;
  // A turn-on spike trips the limit comparator, so only blanking keeps the pulse alive.
  assign peak_cmp_o = gate_i && (ramp >= peak_at_i || ramp < {6'h00, spike_i});
  assign duty_cmp_o = gate_i && ramp >= duty_at_i;
  assign burst_cmp_o = gate_i && ramp >= burst_at_i;
endmodule
`default_nettype wire

// File: testbench/spc_core_checker.sv
// Concurrent checks on the ports of the supply control core.
`default_nettype none
module spc_core_checker
  import spc_pkg::*;
#(
  parameter int SS_CYC = SS_CYCLES,
  parameter int BLANK_CYC = BLANK_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic supply_ok_i,
  input wire logic peak_limit_cmp_i,
  input wire logic fb_low_cmp_i,
  input wire logic fb_high_cmp_i,
  input wire logic blanking_level_cmp_i,
  input wire logic gate_o,
  input wire logic [4:0] soft_start_reference_o,
  input wire logic soft_start_sink_o,
  input wire logic blanking_clamp_switch_o,
  input wire logic burst_mode_o,
  input wire logic auto_restart_o,
  input wire logic latched_off_o
);
  localparam int MAX_ON = (PERIOD_CYCLES + JITTER_CYCLES) * MAX_DUTY_LIMIT_NUM / MAX_DUTY_LIMIT_DEN;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  int on_n, per_n, ss_n, lo_n, hi_n, bl_n;
  int next_on_n, next_per_n, next_ss_n, next_lo_n, next_hi_n, next_bl_n;
  logic seen, next_seen;
  always_comb begin
    next_on_n = gate_o ? on_n + 1 : 0;
    next_per_n = (gate_o && on_n == 0) ? 1 : per_n + 1;
    next_seen = soft_start_sink_o && (seen || (gate_o && on_n == 0));
    next_ss_n = soft_start_sink_o ? ss_n + 1 : 0;
    next_lo_n = fb_low_cmp_i ? lo_n + 1 : 0;
    next_hi_n = (fb_high_cmp_i && !soft_start_sink_o) ? hi_n + 1 : 0;
    next_bl_n = (blanking_level_cmp_i && !blanking_clamp_switch_o) ? bl_n + 1 : 0;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {on_n, per_n, ss_n, lo_n, hi_n, bl_n} <= '0;
      seen <= 1'b0;
    end else begin
      {on_n, per_n, ss_n, lo_n, hi_n, bl_n} <= {next_on_n, next_per_n, next_ss_n, next_lo_n, next_hi_n, next_bl_n};
      seen <= next_seen;
    end
  end
  sequence ss_rise;
    $rose(gate_o) && soft_start_sink_o && seen;
  endsequence
  sequence run_rise;
    $rose(gate_o) && !soft_start_sink_o && !blanking_level_cmp_i && supply_ok_i;
  endsequence
  sequence peak_hold;
    peak_limit_cmp_i [*3] ##0 on_n > 8;
  endsequence
  gate_off_a: assert property (!supply_ok_i [*5] |-> !gate_o)
    else $error("gate on with supply low");
  ss_zero_a: assert property ($rose(soft_start_sink_o) |-> soft_start_reference_o == 5'h00)
    else $error("soft start not from zero");
  step_up_a: assert property (soft_start_sink_o && $past(soft_start_sink_o) && $changed(soft_start_reference_o)
    |-> soft_start_reference_o == $past(soft_start_reference_o) + 5'h01 ##1 $stable(soft_start_reference_o) [*8])
    else $error("bad reference step");
  ss_len_a: assert property ($fell(soft_start_sink_o) && supply_ok_i |-> ss_n inside {[SS_CYC-1:SS_CYC+1]})
    else $error("soft start length wrong");
  max_on_a: assert property (gate_o |-> on_n < MAX_ON)
    else $error("on time over limit");
  ss_period_a: assert property (ss_rise |-> per_n == PERIOD_CYCLES)
    else $error("period moved in soft start");
  jit_range_a: assert property (run_rise and per_n < 150 |-> per_n inside {[96:104]})
    else $error("period out of jitter range");
  leb_hold_a: assert property (run_rise |=> (gate_o || latched_off_o) [*2])
    else $error("pulse cut inside blanking");
  peak_cut_a: assert property (peak_hold |=> !gate_o)
    else $error("peak limit ignored");
  halt_gate_a: assert property ($past(latched_off_o || auto_restart_o) && (latched_off_o || auto_restart_o)
    |-> !gate_o) else $error("gate on while halted");
  clamp_wait_a: assert property ($fell(blanking_clamp_switch_o) |-> hi_n >= BLANK_CYC)
    else $error("clamp released early");
  burst_wait_a: assert property ($rose(burst_mode_o) |-> lo_n >= BLANK_CYC)
    else $error("burst entered early");
  restart_wait_a: assert property ($rose(auto_restart_o) |-> bl_n >= RESTART_SPIKE_CYCLES)
    else $error("restart entered early");
endmodule
bind spc_core spc_core_checker #(.SS_CYC(SS_CYC), .BLANK_CYC(BLANK_CYC)) spc_core_checker_inst (.clk_i, .nrst_i,
  .supply_ok_i, .peak_limit_cmp_i, .fb_low_cmp_i, .fb_high_cmp_i, .blanking_level_cmp_i, .gate_o,
  .soft_start_reference_o, .soft_start_sink_o, .blanking_clamp_switch_o, .burst_mode_o, .auto_restart_o, .latched_off_o);
`default_nettype wire

// File: testbench/smps_pwm_soft_start_blanking_core_bench.sv
// Self-checking bench for the supply control core driving a switch model.
`default_nettype none
module smps_pwm_soft_start_blanking_core_bench
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SS = 2000, STEP = 60, BLANK = 500;
  localparam int LO_ON = (PERIOD_CYCLES - JITTER_CYCLES) * MAX_DUTY_LIMIT_NUM / MAX_DUTY_LIMIT_DEN;
  localparam int HI_ON = (PERIOD_CYCLES + JITTER_CYCLES) * MAX_DUTY_LIMIT_NUM / MAX_DUTY_LIMIT_DEN;
  logic clk_i = 1'b0, nrst_i = 1'b0, supply_on_i = 1'b0, supply_ok_i = 1'b0, short_winding_cmp_i = 1'b0;
  logic fb_low_cmp_i = 1'b0, fb_high_cmp_i = 1'b0, blanking_level_cmp_i = 1'b0, restart_done_i = 1'b0;
  logic duty_cmp_i, peak_limit_cmp_i, burst_limit_cmp_i, gate_o, soft_start_sink_o, blanking_clamp_switch_o;
  logic burst_mode_o, auto_restart_o, latched_off_o;
  logic [4:0] soft_start_reference_o;
  logic [7:0] duty_at = 8'hff, peak_at = 8'hff, burst_at = 8'hff;
  logic [1:0] spike = 2'h0;
  logic [31:0] on_t, per, lo_p = 999, hi_p = 0;
  int mismatches = 0, compares = 0, i, n;
  always #50 clk_i = ~clk_i;
  spc_core #(.SS_CYC(SS), .STEP_CYC(STEP), .BLANK_CYC(BLANK), .JIT_CYC(800)) spc_core_inst (.clk_i, .nrst_i,
    .supply_on_i, .supply_ok_i, .duty_cmp_i, .peak_limit_cmp_i, .burst_limit_cmp_i, .short_winding_cmp_i,
    .fb_low_cmp_i, .fb_high_cmp_i, .blanking_level_cmp_i, .restart_done_i, .gate_o, .soft_start_reference_o,
    .soft_start_sink_o, .blanking_clamp_switch_o, .burst_mode_o, .auto_restart_o, .latched_off_o);
  spc_switch_model spc_switch_model_inst (.clk_i, .gate_i(gate_o), .duty_at_i(duty_at), .peak_at_i(peak_at),
    .burst_at_i(burst_at), .spike_i(spike), .duty_cmp_o(duty_cmp_i), .peak_cmp_o(peak_limit_cmp_i),
    .burst_cmp_o(burst_limit_cmp_i));
  task automatic tick(int k = 1);
    repeat (k) begin
      @(posedge clk_i);
      #10;
    end
  endtask
  task automatic rng(string s, logic [31:0] l, logic [31:0] h, logic [31:0] g);
    compares++;
    if ($isunknown(g) || g < l || g > h) begin
      mismatches++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", s, l, h, g);
    end
  endtask
  // The duty limit follows the jittered period, so the bound spans the shortest and longest period.
  function automatic logic [31:0] cap(logic [31:0] v, logic [31:0] m);
    return (v > m) ? m : v;
  endfunction
  function automatic logic [31:0] ref_at(int t);
    return (t / STEP > 31) ? 31 : t / STEP;
  endfunction
  // Waits for a fresh pulse so that a setting changed mid-pulse never blurs the measurement.
  task automatic pulse();
    for (n = 0; n < 300 && gate_o !== 1'b0; n++) tick();
    for (n = 0; n < 300 && gate_o !== 1'b1; n++) tick();
    on_t = 0;
    per = 0;
    for (n = 0; n < 300 && gate_o === 1'b1; n++) tick();
    on_t = n;
    for (n = 0; n < 300 && gate_o !== 1'b1; n++) tick();
    per = on_t + n;
  endtask
  task automatic soft_start();
    for (n = 0; n < 10 && soft_start_sink_o !== 1'b1; n++) tick();
    rng("sink rise", 0, 5, n);
    rng("first step", 0, 0, soft_start_reference_o);
    tick(STEP * 5 + STEP / 2);
    rng("step", ref_at(STEP * 5 + STEP / 2), ref_at(STEP * 5 + STEP / 2), soft_start_reference_o);
    tick(SS - STEP * 6);
    rng("last step", ref_at(SS - STEP / 2), ref_at(SS - STEP / 2), soft_start_reference_o);
    for (n = 0; n < 40 && soft_start_sink_o === 1'b1; n++) tick();
    rng("soft start length", SS - 1, SS + 1, SS - STEP / 2 + n);
    $display("soft start test done");
  endtask
  task automatic report_and_stop();
    $display("%0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    i = $urandom(32'h965b);
    tick(20);
    nrst_i = 1'b1;
    tick(50);
    rng("clamp at reset", 1, 1, blanking_clamp_switch_o);
    rng("sink before on", 0, 0, soft_start_sink_o);
    supply_ok_i = 1'b1;
    supply_on_i = 1'b1;
    soft_start();
    for (i = 0; i < 30; i++) begin
      duty_at = (i == 0) ? 8'hff : 8'($urandom_range(10, 90));
      spike = 2'($urandom_range(0, 1));
      pulse();
      rng("on time", cap(duty_at, LO_ON), cap(duty_at + 4, HI_ON), on_t);
      rng("period", 96, 104, per);
      lo_p = (per < lo_p) ? per : lo_p;
      hi_p = (per > hi_p) ? per : hi_p;
    end
    rng("jitter spread", 1, 8, hi_p - lo_p);
    duty_at = 8'hff;
    peak_at = 8'd20;
    pulse();
    rng("peak limit", 20, 24, on_t);
    peak_at = 8'hff;
    $display("pwm test done");
    fb_low_cmp_i = 1'b1;
    tick(BLANK - 50);
    fb_low_cmp_i = 1'b0;
    tick(10);
    rng("burst early", 0, 0, burst_mode_o);
    fb_low_cmp_i = 1'b1;
    tick(BLANK + 10);
    fb_low_cmp_i = 1'b0;
    rng("burst", 1, 1, burst_mode_o);
    burst_at = 8'd10;
    pulse();
    rng("burst limit", 10, 14, on_t);
    fb_high_cmp_i = 1'b1;
    tick(BLANK - 50);
    rng("burst exit", 0, 0, burst_mode_o);
    fb_high_cmp_i = 1'b0;
    tick(10);
    rng("clamp early", 1, 1, blanking_clamp_switch_o);
    fb_high_cmp_i = 1'b1;
    for (n = 0; n < BLANK + 20 && blanking_clamp_switch_o !== 1'b0; n++) tick();
    rng("clamp release", BLANK, BLANK + 6, n);
    tick(100);
    rng("extended blanking", 0, 0, auto_restart_o);
    blanking_level_cmp_i = 1'b1;
    for (n = 0; n < 300 && auto_restart_o !== 1'b1; n++) tick();
    rng("restart delay", RESTART_SPIKE_CYCLES, RESTART_SPIKE_CYCLES + 6, n);
    tick(2);
    rng("gate in restart", 0, 0, gate_o);
    {fb_high_cmp_i, blanking_level_cmp_i, restart_done_i} = 3'b001;
    soft_start();
    restart_done_i = 1'b0;
    short_winding_cmp_i = 1'b1;
    tick();
    short_winding_cmp_i = 1'b0;
    tick(10);
    rng("spike filtered", 0, 0, latched_off_o);
    // Held across a whole period so that the detector overlaps an on-time.
    short_winding_cmp_i = 1'b1;
    tick(110);
    rng("latched off", 1, 1, latched_off_o);
    {short_winding_cmp_i, supply_ok_i, supply_on_i} = 3'b000;
    tick(6);
    rng("gate with supply low", 0, 0, gate_o);
    rng("latch cleared", 0, 0, latched_off_o);
    $display("protection test done");
    report_and_stop();
  end
  initial begin
    #(100 * 40000);
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
